/* File: verilog/clock_synth_defs.vh */
// Register offsets, field positions, reset values and timing counts of the synthesizer control
`ifndef CLOCK_SYNTH_DEFS_VH
`define CLOCK_SYNTH_DEFS_VH

// ********************************
// Register offsets
// ********************************
`define CS_ADDR_W          4
`define CS_OFF_CTRL        4'h0
`define CS_OFF_STATUS      4'h1
`define CS_OFF_MASK        4'h2
`define CS_OFF_MULT        4'h3

// ********************************
// Control register fields
// ********************************
`define CS_CTRL_W          16
`define CS_Y_LSB           8
`define CS_Y_MSB           13
`define CS_X_BIT           14
`define CS_W_BIT           15
`define CS_LOCK_BIT        3
`define CS_RANGE_BIT       0
`define CS_CTRL_RESET      8'h3f

// ********************************
// Interrupt status bits
// ********************************
`define CS_IRQ_W           2
`define CS_IRQ_LOCK        0
`define CS_IRQ_UNLOCK      1

// ********************************
// Timing
// ********************************
`define CS_CLK_MHZ         100
`define CS_REF_DIV         16'h0bea
`define CS_LOCK_REF_EDGES  8'h10
`define CS_OVERSHOOT_PCT   16'h001e
`define CS_PCT_SCALE       16'h0064

`endif

/* File: verilog/lock_detector.v */
// Relock timer: counts reference ticks after a loop retune until lock
`timescale 1ns/1ps

`include "clock_synth_defs.vh"

module lock_detector (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire       ref_tick_in,
    input  wire       retune_in,
    input  wire [7:0] lock_edges_in,
    output reg        locked_out
);

    reg [7:0] cnt_q;

    // Retune restarts the count even while one is under way
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_q      <= 8'h00;
            locked_out <= 1'b0;
        end else if (retune_in) begin
            cnt_q      <= 8'h00;
            locked_out <= 1'b0;
        end else if (ref_tick_in && !locked_out) begin
            if (cnt_q == lock_edges_in - 8'h01) begin
                locked_out <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

endmodule

/* File: verilog/slow_ref_pll_frequency_control.v */
// Frequency control of the slow-reference clock synthesizer, with register port and lock flag
//
// Behaviour
// - Multiplier is 4*(Y+1)*2^(2W+X)
// - Speed-up may overshoot up to 30 percent
// - X bypasses output divider, no relock
// - Lock flag set when loop relocks
// - Any W or Y change forces relock
// - Oscillator runs 4x or 2x system clock
// - Upper control byte resets to 3f
// - Slow mode chosen by pin low in reset
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

`include "clock_synth_defs.vh"

module slow_ref_pll_frequency_control (
    input  wire                   clk_in,
    input  wire                   resetn_in,
    input  wire [`CS_ADDR_W-1:0]  addr_in,
    input  wire [15:0]            wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    input  wire                   reference_speed_select_in,
    output reg  [15:0]            rdata_out,
    output reg                    irq_out,
    output reg                    pll_lock_flag_out,
    output reg                    slow_ref_mode_out,
    output reg  [11:0]            sys_multiplier_out,
    output reg  [11:0]            vco_multiplier_out,
    output reg  [11:0]            overshoot_multiplier_out,
    output reg                    out_div2_bypass_out
);

    // ********************************
    // Helpers
    // ********************************
    function [11:0] sys_mult;
        input [5:0] y;
        input       w;
        input       x;
        reg   [11:0] base;
        begin
            base     = {4'h0, 2'b00, y} + 12'h001;
            sys_mult = (base << 2) << {w, x};
        end
    endfunction

    // Oscillator sits before the output divider, so it ignores X
    function [11:0] vco_mult;
        input [5:0] y;
        input       w;
        begin
            // Wraps to zero only at settings software must never program
            vco_mult = sys_mult(y, w, 1'b1) << 1;
        end
    endfunction

    // Decode shared by every register write strobe
    function reg_hit;
        input                  strobe;
        input [`CS_ADDR_W-1:0] addr;
        input [`CS_ADDR_W-1:0] offset;
        begin
            reg_hit = strobe && (addr == offset);
        end
    endfunction

    // Worst-case transient bound; 16-bit product so 2048 cannot wrap
    function [11:0] overshoot_bound;
        input [11:0] mult;
        reg   [15:0] wide;
        begin
            wide            = {4'h0, mult} +
                              ({4'h0, mult} * `CS_OVERSHOOT_PCT) / `CS_PCT_SCALE;
            overshoot_bound = wide[11:0];
        end
    endfunction

    // Control word as software sees it; lock is read-only
    function [15:0] ctrl_word;
        input [5:0] y;
        input       w;
        input       x;
        input       lock;
        input       spare;
        begin
            ctrl_word = {w, x, y, 4'h0, lock, 2'b00, spare};
        end
    endfunction

    // ********************************
    // Pin synchroniser and strap capture
    // ********************************
    reg        sel_meta_q;
    reg        sel_sync_q;
    reg        in_reset_q;
    reg        fast_ref_q;

    always @(posedge clk_in) begin
        sel_meta_q <= reference_speed_select_in;
        sel_sync_q <= sel_meta_q;
    end

    // Strap latched on the first edge after release, from the synchronised pin
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            in_reset_q <= 1'b1;
            fast_ref_q <= 1'b0;
        end else if (in_reset_q) begin
            in_reset_q <= 1'b0;
            fast_ref_q <= sel_sync_q;
        end
    end

    // ********************************
    // Reference tick divider
    // ********************************
    reg [15:0] ref_cnt_q;
    reg        ref_tick_q;

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            ref_cnt_q  <= 16'h0000;
            ref_tick_q <= 1'b0;
        end else if (ref_cnt_q == `CS_REF_DIV - 16'h0001) begin
            ref_cnt_q  <= 16'h0000;
            ref_tick_q <= 1'b1;
        end else begin
            ref_cnt_q  <= ref_cnt_q + 16'h0001;
            ref_tick_q <= 1'b0;
        end
    end

    // ********************************
    // Control register
    // ********************************
    reg  [5:0] y_q;
    reg        w_q;
    reg        x_q;
    reg        range_lo_q;
    reg  [1:0] status_q;
    reg  [1:0] mask_q;
    reg        locked_prev_q;
    wire       locked;
    wire       ctrl_wr;
    wire       status_wr;
    wire       mask_wr;
    wire       retune;
    wire       lock_ok;

    assign ctrl_wr   = reg_hit(wr_in, addr_in, `CS_OFF_CTRL);
    assign status_wr = reg_hit(wr_in, addr_in, `CS_OFF_STATUS);
    assign mask_wr   = reg_hit(wr_in, addr_in, `CS_OFF_MASK);
    // Only loop-internal fields force a relock; X alone does not
    assign retune  = ctrl_wr && ((wdata_in[`CS_Y_MSB:`CS_Y_LSB] != y_q) ||
                                 (wdata_in[`CS_W_BIT] != w_q));
    // Flag and overshoot bound share one view, so both move on the write edge
    assign lock_ok = locked && !retune;

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            {w_q, x_q, y_q} <= `CS_CTRL_RESET;
            range_lo_q      <= 1'b0;
        end else if (ctrl_wr) begin
            y_q        <= wdata_in[`CS_Y_MSB:`CS_Y_LSB];
            w_q        <= wdata_in[`CS_W_BIT];
            x_q        <= wdata_in[`CS_X_BIT];
            range_lo_q <= wdata_in[`CS_RANGE_BIT];
        end
    end

    // ********************************
    // Relock tracking
    // ********************************
    // A second W or Y change mid-relock restarts the whole wait
    lock_detector u_lock (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .ref_tick_in   (ref_tick_q),
        .retune_in     (retune),
        .lock_edges_in (`CS_LOCK_REF_EDGES),
        .locked_out    (locked)
    );

    // ********************************
    // Interrupt status and mask
    // ********************************
    wire lock_rise;
    wire lock_fall;

    assign lock_rise = locked && !locked_prev_q;
    assign lock_fall = !locked && locked_prev_q;

    // Edge memory for the lock event bits
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            locked_prev_q <= 1'b0;
        end else begin
            locked_prev_q <= locked;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            status_q <= 2'b00;
        end else begin
            status_q[`CS_IRQ_LOCK] <= lock_rise ||
                (status_q[`CS_IRQ_LOCK] && !(status_wr && wdata_in[`CS_IRQ_LOCK]));
            status_q[`CS_IRQ_UNLOCK] <= lock_fall ||
                (status_q[`CS_IRQ_UNLOCK] && !(status_wr && wdata_in[`CS_IRQ_UNLOCK]));
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            mask_q <= 2'b00;
        end else if (mask_wr) begin
            mask_q <= wdata_in[`CS_IRQ_W-1:0];
        end
    end

    // ********************************
    // Interrupt, lock and mode outputs
    // ********************************
    wire [11:0] sys_now = sys_mult(y_q, w_q, x_q);
    wire [11:0] vco_now = vco_mult(y_q, w_q);

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_out           <= 1'b0;
            pll_lock_flag_out <= 1'b0;
            slow_ref_mode_out <= 1'b0;
        end else begin
            irq_out           <= |(status_q & mask_q);
            pll_lock_flag_out <= lock_ok;
            // Held low until the strap has been taken after reset
            slow_ref_mode_out <= !fast_ref_q && !in_reset_q;
        end
    end

    // ********************************
    // Multiplier outputs
    // ********************************
    // All three move on one edge, so ratios never show a mixed state
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            sys_multiplier_out  <= 12'h000;
            vco_multiplier_out  <= 12'h000;
            out_div2_bypass_out <= 1'b0;
        end else begin
            sys_multiplier_out  <= sys_now;
            vco_multiplier_out  <= vco_now;
            out_div2_bypass_out <= x_q;
        end
    end

    // ********************************
    // Overshoot bound
    // ********************************
    // Reports the ceiling a clock may reach before relock; nothing is shaped here
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            overshoot_multiplier_out <= 12'h000;
        end else if (lock_ok) begin
            overshoot_multiplier_out <= sys_now;
        end else begin
            overshoot_multiplier_out <= overshoot_bound(sys_now);
        end
    end

    // ********************************
    // Read port
    // ********************************
    // Idle zero keeps a stale word from looking like a fresh read
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `CS_OFF_CTRL: begin
                    rdata_out <= ctrl_word(y_q, w_q, x_q, locked, range_lo_q);
                end
                `CS_OFF_STATUS: begin
                    rdata_out <= {14'h0000, status_q};
                end
                `CS_OFF_MASK: begin
                    rdata_out <= {14'h0000, mask_q};
                end
                `CS_OFF_MULT: begin
                    rdata_out <= {4'h0, sys_now};
                end
                default: begin
                    rdata_out <= 16'h0000;
                end
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end

endmodule

/* File: tb/clock_synth_props.sv */
// Port assertions for the slow-reference synthesizer control
`timescale 1ns/1ps
`include "clock_synth_defs.vh"
module clock_synth_checker (
    input wire        clk_in,
    input wire        resetn_in,
    input wire [3:0]  addr_in,
    input wire        rd_in,
    input wire [15:0] rdata_out,
    input wire        pll_lock_flag_out,
    input wire        slow_ref_mode_out,
    input wire [11:0] sys_multiplier_out,
    input wire [11:0] vco_multiplier_out,
    input wire [11:0] overshoot_multiplier_out,
    input wire        out_div2_bypass_out
);
    // ****
    // Checks
    // ****
    wire [15:0] boost = ({4'h0, sys_multiplier_out} * 16'h000d) / 16'h000a;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence odd_rd;
        rd_in && addr_in > `CS_OFF_MULT;
    endsequence
    sequence mult_rd;
        rd_in && addr_in == `CS_OFF_MULT;
    endsequence
    read_idle_a: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data not idle");
    unmapped_zero_a: assert property (odd_rd |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    mult_read_a: assert property (mult_rd |=> rdata_out == {4'h0, sys_multiplier_out})
        else $error("multiplier read wrong");
    vco_ratio_a: assert property (sys_multiplier_out < 12'h400 |-> vco_multiplier_out ==
        (out_div2_bypass_out ? sys_multiplier_out << 1 : sys_multiplier_out << 2))
        else $error("oscillator ratio wrong");
    bypass_double_a: assert property ($rose(out_div2_bypass_out) && $stable(vco_multiplier_out)
        |-> sys_multiplier_out == {$past(sys_multiplier_out[10:0]), 1'b0})
        else $error("bypass did not double");
    retune_unlock_a: assert property ($changed(vco_multiplier_out) |-> !pll_lock_flag_out)
        else $error("lock kept over retune");
    overshoot_a: assert property (overshoot_multiplier_out ==
        (pll_lock_flag_out ? sys_multiplier_out : boost[11:0]))
        else $error("overshoot figure wrong");
    slow_mode_a: assert property (resetn_in && $past(resetn_in, 3) |-> $stable(slow_ref_mode_out))
        else $error("mode changed after reset");
endmodule
bind slow_ref_pll_frequency_control clock_synth_checker chk_u (.clk_in(clk_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pll_lock_flag_out(pll_lock_flag_out), .slow_ref_mode_out(slow_ref_mode_out),
    .sys_multiplier_out(sys_multiplier_out), .vco_multiplier_out(vco_multiplier_out),
    .overshoot_multiplier_out(overshoot_multiplier_out),
    .out_div2_bypass_out(out_div2_bypass_out));

/* File: tb/slow_ref_pll_frequency_control_bench.sv */
// Self-checking bench for the slow-reference synthesizer control
`timescale 1ns/1ps
`include "clock_synth_defs.vh"
module slow_ref_pll_frequency_control_bench;
    reg         clk_in = 1'b0;
    reg         resetn_in = 1'b0;
    reg  [3:0]  addr_in = 4'h0;
    reg  [15:0] wdata_in = 16'h0000;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg         strap = 1'b0;
    wire [15:0] rdata_out;
    wire        irq_out, lock, slow, byp;
    wire [11:0] sys, vco, ovs;
    integer     errors = 0;
    integer     total_checks = 0;
    integer     i;
    slow_ref_pll_frequency_control dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .reference_speed_select_in(strap), .rdata_out(rdata_out), .irq_out(irq_out),
        .pll_lock_flag_out(lock), .slow_ref_mode_out(slow), .sys_multiplier_out(sys),
        .vco_multiplier_out(vco), .overshoot_multiplier_out(ovs), .out_div2_bypass_out(byp));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // ****
    // Bus tasks
    // ****
    task check(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // Returns once the new settings reach the outputs
    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge clk_in);
            wr_in <= 1'b0;
            repeat (2) @(posedge clk_in);
            #1;
        end
    endtask
    task rd_chk(input [3:0] a, input [15:0] exp);
        begin
            @(posedge clk_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge clk_in);
            rd_in <= 1'b0;
            #1;
            check(rdata_out, exp);
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d errors=%0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        check({15'h0, slow}, 16'h0001);
        rd_chk(`CS_OFF_CTRL, 16'h3f00);
        check({4'h0, vco}, 16'h0400);
        rd_chk(`CS_OFF_MULT, 16'h0100);
        rd_chk(4'h7, 16'h0000);
        // Relock from reset is long, so only one full lock is awaited
        for (i = 0; i < 60000 && lock !== 1'b1; i = i + 1)
            @(posedge clk_in);
        if (lock !== 1'b1) begin
            errors = errors + 1;
            print_verdict;
        end
        #1;
        rd_chk(`CS_OFF_CTRL, 16'h3f08);
        check({4'h0, ovs}, 16'h0100);
        rd_chk(`CS_OFF_STATUS, 16'h0001);
        wr_reg(`CS_OFF_MASK, 16'h0001);
        check({15'h0, irq_out}, 16'h0001);
        wr_reg(`CS_OFF_STATUS, 16'h0001);
        check({15'h0, irq_out}, 16'h0000);
        wr_reg(`CS_OFF_CTRL, 16'h7f00);
        check({14'h0, lock, byp}, 16'h0003);
        check({4'h0, sys}, 16'h0200);
        wr_reg(`CS_OFF_CTRL, 16'h2d00);
        check({15'h0, lock}, 16'h0000);
        check({4'h0, ovs}, 16'h00ef);
        wr_reg(`CS_OFF_MASK, 16'h0002);
        check({15'h0, irq_out}, 16'h0001);
        wr_reg(`CS_OFF_STATUS, 16'h0002);
        rd_chk(`CS_OFF_STATUS, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(`CS_OFF_CTRL, {i[0], i[1], 14'h2d00});
            check({4'h0, sys}, 16'h00b8 << (2 * i[0] + i[1]));
        end
        wr_reg(`CS_OFF_CTRL, 16'hff00);
        check({4'h0, sys}, 16'h0800);
        // Second reset with the pin high: slow mode must stay off
        @(posedge clk_in);
        strap <= 1'b1;
        resetn_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        check({15'h0, slow}, 16'h0000);
        check({4'h0, sys}, 16'h0100);
        rd_chk(`CS_OFF_CTRL, 16'h3f00);
        print_verdict;
    end
endmodule
